/* gpio_pin_share.sv */
// two-port pin sharing: direction, pull-up, data latches, pin takeover
// assumes a pad ring that turns out/oe/pull into real pads and analog switches
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module gpio_pin_share (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       reset_pin_option,
    input  wire logic [2:0] cmp_enable,
    input  wire logic [2:0] cmp_pin_out_enable,
    input  wire logic [2:0] cmp_pin_output,
    input  wire logic       buzzer_output,
    input  wire logic       pulse_width_output,
    input  wire logic       serial_transmit_pin,
    output logic            serial_receive_pin,
    output logic            external_interrupt_input,
    output logic            ext_reset_n,
    input  wire logic [5:0] p0_in,
    output logic [5:0]      p0_out,
    output logic [5:0]      p0_oe,
    output logic [5:0]      p0_pullup,
    output logic [5:0]      p0_analog,
    input  wire logic [7:0] p4_in,
    output logic [7:0]      p4_out,
    output logic [7:0]      p4_oe,
    output logic [7:0]      p4_pullup,
    output logic [7:0]      p4_analog,
    output logic            irq
);
    import gpio_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] p0_dir_q, p4_dir_q, p0_data_q, p4_data_q, p0_pull_q, p4_pull_q;
    logic [7:0] func_q, adc_q, stat_q, mask_q;
    logic [5:0] p0_s1_q, p0_s2_q;
    logic [7:0] p4_s1_q, p4_s2_q;
    logic       ext_hit;
    logic [7:0] rdata_d;
    logic [7:0] p4_rd_val;
    logic [7:0] stat_clr;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            p0_s1_q <= 6'h00;
            p0_s2_q <= 6'h00;
            p4_s1_q <= 8'h00;
            p4_s2_q <= 8'h00;
        end else begin
            p0_s1_q <= p0_in;
            p0_s2_q <= p0_s1_q;
            p4_s1_q <= p4_in;
            p4_s2_q <= p4_s1_q;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            p0_dir_q  <= RESET_VALUE;
            p4_dir_q  <= RESET_VALUE;
            p0_data_q <= RESET_VALUE;
            p4_data_q <= RESET_VALUE;
            p0_pull_q <= RESET_VALUE;
            p4_pull_q <= RESET_VALUE;
            func_q    <= RESET_VALUE;
            adc_q     <= RESET_VALUE;
            mask_q    <= RESET_VALUE;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_P0_DIR:   p0_dir_q  <= reg_wdata & P0_DIR_MASK;
                ADDR_P4_DIR:   p4_dir_q  <= reg_wdata;
                ADDR_P0_DATA:  p0_data_q <= reg_wdata & P0_DATA_MASK;
                ADDR_P4_DATA:  p4_data_q <= reg_wdata;
                ADDR_P0_PULL:  p0_pull_q <= reg_wdata & P0_PULL_MASK;
                ADDR_P4_PULL:  p4_pull_q <= reg_wdata & P4_PULL_MASK;
                ADDR_FUNC:     func_q    <= reg_wdata;
                ADDR_ADC:      adc_q     <= reg_wdata;
                ADDR_IRQ_MASK: mask_q    <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // external interrupt event
    // ****************************************
    edge_detect u_edge (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .level   (p0_s2_q[0]),
        .mode    (edge_type'(func_q[FN_EDGE +: FN_EDGE_W])),
        .hit     (ext_hit)
    );

    assign stat_clr = (reg_wr && reg_addr == ADDR_IRQ_STAT) ? reg_wdata : 8'h00;

    // flag sets on the edge whatever the enable; set wins over clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= RESET_VALUE;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | {7'h00, ext_hit};
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q & {7'h7F, func_q[FN_EXT_IEN]});
        end
    end

    // ****************************************
    // pin function selection
    // ****************************************
    logic [5:0] p0_out_d, p0_oe_d, p0_an_d;
    logic [7:0] p4_out_d, p4_oe_d, p4_an_d;
    logic       rst_sel;
    assign rst_sel = reset_pin_option;

    always_comb begin
        p0_out_d = p0_data_q[5:0];
        p0_oe_d  = p0_dir_q[5:0];
        p0_oe_d[1] = 1'b1;
        p0_an_d  = 6'h00;
        if (func_q[FN_BUZZ]) begin
            p0_out_d[0] = buzzer_output;
            p0_oe_d[0]  = 1'b1;
        end else if (func_q[FN_EXT_IEN]) begin
            p0_oe_d[0]  = 1'b0;
        end
        if (func_q[FN_PWM]) begin
            p0_out_d[1] = pulse_width_output;
        end
        p0_an_d[2] = cmp_enable[0];
        p0_an_d[3] = cmp_enable[0];
        p0_an_d[4] = cmp_enable[1];
        p0_an_d[5] = cmp_enable[2];
        for (int i = 2; i < 6; i++) begin
            if (p0_an_d[i]) begin
                p0_oe_d[i] = 1'b0;
            end
        end
    end

    always_comb begin
        p4_out_d = p4_data_q;
        p4_oe_d  = p4_dir_q;
        p4_an_d  = 8'h00;
        for (int i = 0; i < 3; i++) begin
            if (cmp_enable[i] && cmp_pin_out_enable[i]) begin
                p4_out_d[5 - i] = cmp_pin_output[i];
                p4_oe_d[5 - i]  = 1'b1;
            end
        end
        if (func_q[FN_UTX]) begin
            p4_out_d[6] = serial_transmit_pin;
            p4_oe_d[6]  = 1'b1;
        end
        if (func_q[FN_URX]) begin
            p4_oe_d[7] = 1'b0;
        end
        if (adc_q[AD_ENABLE] && adc_q[AD_GLOBAL] && adc_q[AD_SEL_LSB +: AD_SEL_W] != 3'h7) begin
            p4_an_d[adc_q[AD_SEL_LSB +: AD_SEL_W]] = 1'b1;
        end
        if (func_q[FN_OPAMP]) begin
            p4_an_d[2:0] = 3'h7;
        end
        for (int i = 0; i < 7; i++) begin
            if (p4_an_d[i]) begin
                p4_oe_d[i] = 1'b0;
            end
        end
        if (rst_sel) begin
            p4_oe_d[7] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            p0_out    <= 6'h00;
            p0_oe     <= 6'h00;
            p0_pullup <= 6'h00;
            p0_analog <= 6'h00;
            p4_out    <= 8'h00;
            p4_oe     <= 8'h00;
            p4_pullup <= 8'h00;
            p4_analog <= 8'h00;
        end else begin
            p0_out    <= p0_out_d;
            p0_oe     <= p0_oe_d;
            p0_pullup <= p0_pull_q[5:0] & ~p0_oe_d & ~p0_an_d;
            p0_analog <= p0_an_d;
            p4_out    <= p4_out_d;
            p4_oe     <= p4_oe_d;
            p4_pullup <= p4_pull_q & ~p4_oe_d & ~p4_an_d;
            p4_analog <= p4_an_d;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_receive_pin       <= 1'b1;
            external_interrupt_input <= 1'b0;
            ext_reset_n              <= 1'b1;
        end else begin
            serial_receive_pin       <= func_q[FN_URX] ? p4_s2_q[7] : 1'b1;
            external_interrupt_input <= func_q[FN_EXT_IEN] & p0_s2_q[0];
            ext_reset_n              <= rst_sel ? p4_s2_q[7] : 1'b1;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p4_rd_val[i] = p4_dir_q[i] ? p4_data_q[i] : p4_s2_q[i];
        end
        if (rst_sel) begin
            p4_rd_val[7] = 1'b1;
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            ADDR_P0_DIR:   rdata_d = p0_dir_q;
            ADDR_P4_DIR:   rdata_d = p4_dir_q;
            ADDR_P0_DATA: begin
                for (int i = 0; i < 6; i++) begin
                    rdata_d[i] = p0_dir_q[i] ? p0_data_q[i] : p0_s2_q[i];
                end
                rdata_d[1] = 1'b0;
            end
            ADDR_P4_DATA:  rdata_d = p4_rd_val;
            ADDR_FUNC:     rdata_d = func_q;
            ADDR_ADC:      rdata_d = adc_q;
            ADDR_IRQ_STAT: rdata_d = stat_q;
            ADDR_IRQ_MASK: rdata_d = mask_q;
            default:       rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end
endmodule

/* gpio_pkg.sv */
// constants for the two-port pin-share block; no surroundings assumed
package gpio_pkg;
    localparam logic [7:0] ADDR_P0_DIR   = 8'hB8;
    localparam logic [7:0] ADDR_P4_DIR   = 8'hC4;
    localparam logic [7:0] ADDR_P0_DATA  = 8'hD0;
    localparam logic [7:0] ADDR_P4_DATA  = 8'hD4;
    localparam logic [7:0] ADDR_P0_PULL  = 8'hE0;
    localparam logic [7:0] ADDR_P4_PULL  = 8'hE4;
    localparam logic [7:0] ADDR_FUNC     = 8'hF0;
    localparam logic [7:0] ADDR_ADC      = 8'hF1;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hF2;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hF3;
    // implemented bits per register
    localparam logic [7:0] P0_DIR_MASK   = 8'h3D;
    localparam logic [7:0] P0_PULL_MASK  = 8'h3D;
    localparam logic [7:0] P0_DATA_MASK  = 8'h3F;
    localparam logic [7:0] P4_PULL_MASK  = 8'h7F;
    localparam logic [7:0] RESET_VALUE   = 8'h00;
    // function register fields
    localparam int FN_EXT_IEN  = 0;
    localparam int FN_EDGE     = 1;
    localparam int FN_BUZZ     = 7;
    localparam int FN_PWM      = 3;
    localparam int FN_OPAMP    = 4;
    localparam int FN_UTX      = 5;
    localparam int FN_URX      = 6;
    localparam int FN_EDGE_W   = 2;
    // converter register fields
    localparam int AD_ENABLE   = 7;
    localparam int AD_GLOBAL   = 4;
    localparam int AD_SEL_LSB  = 0;
    localparam int AD_SEL_W    = 3;
    // status bit of the external pin event
    localparam int ST_EXT      = 0;
    typedef enum logic [1:0] {
        EDGE_FALL,
        EDGE_RISE,
        EDGE_BOTH,
        EDGE_NONE
    } edge_type;
endpackage

/* edge_detect.sv */
// edge detector for the external interrupt pin
// assumes its input already synchronised to ref_clk
`timescale 1ns/1ps
module edge_detect (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             level,
    input  wire gpio_pkg::edge_type mode,
    output logic                  hit
);
    import gpio_pkg::*;
    logic prev_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end
    always_comb begin
        case (mode)
            EDGE_FALL: hit = prev_q & ~level;
            EDGE_RISE: hit = ~prev_q & level;
            EDGE_BOTH: hit = prev_q ^ level;
            default:   hit = 1'b0;
        endcase
    end
endmodule

/* board_model.sv */
// board side of the fourteen pads
// assumes pad outputs of the pin-share block and levels set by the bench
`timescale 1ns/1ps
module board_model (
    input  wire logic [5:0] p0_out,
    input  wire logic [5:0] p0_oe,
    input  wire logic [5:0] p0_pullup,
    input  wire logic [5:0] p0_ext,
    input  wire logic [7:0] p4_out,
    input  wire logic [7:0] p4_oe,
    input  wire logic [7:0] p4_pullup,
    input  wire logic [7:0] p4_ext,
    output logic [5:0]      p0_in,
    output logic [7:0]      p4_in
);
    // a driven pad shows its latch, a released pad with pull-up reads high
    assign p0_in = (p0_oe & p0_out) | (~p0_oe & (p0_pullup | p0_ext));
    assign p4_in = (p4_oe & p4_out) | (~p4_oe & (p4_pullup | p4_ext));
endmodule

/* gpio_pin_share_properties.sv */
// port-level properties of the pin-share block
// assumes a bind onto gpio_pin_share
`timescale 1ns/1ps
module gpio_pin_share_properties (
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reset_pin_option,
    input wire logic       ext_reset_n,
    input wire logic [5:0] p0_oe,
    input wire logic [5:0] p0_pullup,
    input wire logic [7:0] p4_in,
    input wire logic [7:0] p4_oe,
    input wire logic [7:0] p4_pullup,
    input wire logic [7:0] p4_analog,
    input wire logic       irq
);
    import gpio_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_pull_only_input: assert property (~|(p4_pullup & p4_oe) && ~|(p0_pullup & p0_oe))
        else $error("pull-up on a driven pad");
    a_no_pull_bits: assert property (!p4_pullup[7] && !p0_pullup[1])
        else $error("pull-up on a pad without one");
    a_p01_drives: assert property ($past(arst_n) |-> p0_oe[1])
        else $error("output-only pad not driven");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_p0_data_holes: assert property (reg_rd && reg_addr == ADDR_P0_DATA |=> (reg_rdata & 8'hC2) == 8'h00)
        else $error("write-only data bit readable");
    a_p0_dir_holes: assert property (reg_rd && reg_addr == ADDR_P0_DIR |=> (reg_rdata & ~P0_DIR_MASK) == 8'h00)
        else $error("absent direction bit readable");
    a_p47_reads_one: assert property (reg_rd && reg_addr == ADDR_P4_DATA && reset_pin_option |=> reg_rdata[7])
        else $error("reset pad data bit not one");
    a_reset_pin_off: assert property (!reset_pin_option ##1 !reset_pin_option |-> ext_reset_n)
        else $error("reset asserted without option");
    a_reset_pin_low: assert property ((reset_pin_option && !p4_in[7]) [*5] |-> !ext_reset_n)
        else $error("low reset pad not passed on");
    a_adc_single: assert property ($onehot0(p4_analog[6:3]))
        else $error("two converter pads at once");
    c_irq: cover property (irq);
    c_reset_pin: cover property (!ext_reset_n);
    c_adc: cover property (|p4_analog);
endmodule

/* testbench.sv */
// self-checking bench for the pin-share block
// assumes package, design, board model and checker compiled before
`timescale 1ns/1ps
module testbench;
    import gpio_pkg::*;
    logic       ref_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, r, d;
    logic       reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0, reset_pin_option = 1'b0;
    logic       buzzer_output = 1'b0, pulse_width_output = 1'b0, serial_transmit_pin = 1'b0;
    logic [2:0] cmp_enable = 3'h0, cmp_pin_out_enable = 3'h0, cmp_pin_output = 3'h0;
    logic [5:0] p0_ext = 6'h00, p0_in, p0_out, p0_oe, p0_pullup, p0_analog;
    logic [7:0] p4_ext = 8'h00, p4_in, p4_out, p4_oe, p4_pullup, p4_analog;
    logic       serial_receive_pin, external_interrupt_input, ext_reset_n, irq;
    logic [7:0] exp_q[$];
    int         n_mismatch = 0, total_checks = 0, cycles = 0;

    gpio_pin_share dut (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reset_pin_option, .cmp_enable, .cmp_pin_out_enable, .cmp_pin_output, .buzzer_output,
        .pulse_width_output, .serial_transmit_pin, .serial_receive_pin, .external_interrupt_input,
        .ext_reset_n, .p0_in, .p0_out, .p0_oe, .p0_pullup, .p0_analog, .p4_in, .p4_out, .p4_oe,
        .p4_pullup, .p4_analog, .irq);
    board_model board (.p0_out, .p0_oe, .p0_pullup, .p0_ext, .p4_out, .p4_oe, .p4_pullup,
        .p4_ext, .p0_in, .p4_in);

    always #20 ref_clk = ~ref_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // read data stands in the cycle after the strobe
    always @(posedge ref_clk) begin
        rd_seen <= reg_rd;
        if (rd_seen && exp_q.size() > 0)
            check(reg_rdata, exp_q.pop_front());
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(98480));
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(ADDR_P0_DIR, 8'h00);
        rd(ADDR_P4_DIR, 8'h00);
        rd(ADDR_P0_DATA, 8'h00);
        rd(ADDR_P4_DATA, 8'h00);
        rd(8'h55, 8'h00);
        check({2'b00, p0_oe}, 8'h02);
        check(p4_oe, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom);
            d = 8'($urandom);
            p4_ext <= 8'($urandom);
            wr(ADDR_P4_DIR, r);
            wr(ADDR_P4_DATA, d);
            repeat (4) @(posedge ref_clk);
            check(p4_oe, r);
            check(p4_out & r, d & r);
            rd(ADDR_P4_DATA, (d & r) | (p4_ext & ~r));
        end
        wr(ADDR_P0_DIR, 8'hFF);
        wr(ADDR_P0_DATA, 8'h02);
        rd(ADDR_P0_DIR, 8'h3D);
        repeat (2) @(posedge ref_clk);
        check({2'b00, p0_oe}, 8'h3F);
        check({7'h00, p0_out[1]}, 8'h01);
        wr(ADDR_P0_DIR, 8'h00);
        wr(ADDR_P4_DIR, 8'h00);
        $display("test pins done");
        wr(ADDR_P0_PULL, 8'hFF);
        wr(ADDR_P4_PULL, 8'hFF);
        repeat (2) @(posedge ref_clk);
        check({2'b00, p0_pullup}, 8'h3D);
        check(p4_pullup, 8'h7F);
        wr(ADDR_P4_DIR, 8'hF0);
        repeat (2) @(posedge ref_clk);
        check(p4_pullup, 8'h0F);
        wr(ADDR_P4_DIR, 8'h00);
        wr(ADDR_P0_PULL, 8'h00);
        wr(ADDR_P4_PULL, 8'h00);
        $display("test pullup done");
        for (int m = 0; m < 3; m++) begin
            p0_ext[0] <= 1'b0;
            wr(ADDR_FUNC, (m == 2) ? 8'h02 : 8'h03);
            wr(ADDR_IRQ_MASK, 8'(m != 0));
            wr(ADDR_IRQ_STAT, 8'hFF);
            p0_ext[0] <= 1'b1;
            repeat (8) @(posedge ref_clk);
            check({7'h00, irq}, 8'(m == 1));
            check({7'h00, external_interrupt_input}, 8'(m != 2));
            rd(ADDR_IRQ_STAT, 8'h01);
            wr(ADDR_IRQ_STAT, 8'h01);
            repeat (3) @(posedge ref_clk);
            check({7'h00, irq}, 8'h00);
        end
        wr(ADDR_FUNC, 8'h00);
        $display("test interrupt done");
        for (int n = 0; n < 32; n++) begin
            wr(ADDR_ADC, {n[4], 2'b00, ~n[3], 1'b0, n[2:0]});
            repeat (3) @(posedge ref_clk);
            check(p4_analog, (n[4] && !n[3] && n[2:0] != 3'h7) ? 8'h01 << n[2:0] : 8'h00);
        end
        wr(ADDR_ADC, 8'h00);
        $display("test converter done");
        reset_pin_option <= 1'b1;
        p4_ext <= 8'h00;
        repeat (6) @(posedge ref_clk);
        check({7'h00, ext_reset_n}, 8'h00);
        rd(ADDR_P4_DATA, 8'h80);
        reset_pin_option <= 1'b0;
        $display("test reset pin done");
        d = 8'($urandom);
        buzzer_output <= d[0];
        pulse_width_output <= d[1];
        serial_transmit_pin <= d[2];
        p4_ext <= {d[3], 7'h00};
        wr(ADDR_FUNC, 8'hF8);
        repeat (4) @(posedge ref_clk);
        check({6'h00, p0_oe[0], p0_out[0]}, {6'h00, 1'b1, d[0]});
        check({7'h00, p0_out[1]}, {7'h00, d[1]});
        check({6'h00, p4_oe[6], p4_out[6]}, {6'h00, 1'b1, d[2]});
        check({7'h00, serial_receive_pin}, {7'h00, d[3]});
        check({p4_oe[2:0], p4_analog[4:0]}, 8'h07);
        wr(ADDR_FUNC, 8'h00);
        $display("test functions done");
        cmp_enable <= 3'h7;
        cmp_pin_out_enable <= 3'h7;
        cmp_pin_output <= 3'($urandom);
        repeat (4) @(posedge ref_clk);
        check(p4_oe & 8'h38, 8'h38);
        check({2'b00, p0_analog}, 8'h3C);
        check(p4_out & 8'h38, {2'b00, cmp_pin_output[0], cmp_pin_output[1], cmp_pin_output[2], 3'b000});
        $display("test comparator done");
        repeat (3) @(posedge ref_clk);
        finish_test();
    end
endmodule

bind gpio_pin_share gpio_pin_share_properties props (.ref_clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata,
    .reset_pin_option, .ext_reset_n, .p0_oe, .p0_pullup, .p4_in, .p4_oe, .p4_pullup, .p4_analog, .irq);
